// [common/tapid_params.svh]
`ifndef TAPID_PARAMS_SVH
`define TAPID_PARAMS_SVH
// ============================================================
// Instruction register
`define TAPID_IR_W 3
// Codes written MSB on the left, LSB on the right
`define TAPID_IR_EXTEST 3'h0
`define TAPID_IR_IDCODE 3'h1
`define TAPID_IR_SAMPLEZ 3'h2
`define TAPID_IR_PRELOAD 3'h4
`define TAPID_IR_BYPASS 3'h7
`define TAPID_IR_PRIV_A 3'h3
`define TAPID_IR_PRIV_B 3'h5
`define TAPID_IR_PRIV_C 3'h6
`define TAPID_IR_CAPTURE 2'h1
`define TAPID_IR_CAP_MSB 1'h0
// ============================================================
// Data registers
`define TAPID_ID_W 32
`define TAPID_BSR_LEN 8
`define TAPID_BSR_PIN_MASK 8'h3F
`define TAPID_BSR_DEFAULT 8'hC0
`define TAPID_BYP_CAPTURE 1'h0
// ============================================================
// Pin synchroniser lanes
`define TAPID_SYNC_W 11
`define TAPID_PIN_TCK 0
`define TAPID_PIN_TMS 1
`define TAPID_PIN_TDI 2
`define TAPID_PIN_MEM 3
`endif

// [common/tapid_pkg.sv]
`include "tapid_params.svh"
package tapid_pkg;
  // ============================================================
  // TAP controller states
  typedef enum logic [3:0] {
    TAPID_TLR, TAPID_RTI, TAPID_SEL_DR, TAPID_CAP_DR, TAPID_SH_DR, TAPID_EX1_DR,
    TAPID_PA_DR, TAPID_EX2_DR, TAPID_UPD_DR, TAPID_SEL_IR, TAPID_CAP_IR, TAPID_SH_IR,
    TAPID_EX1_IR, TAPID_PA_IR, TAPID_EX2_IR, TAPID_UPD_IR
  } tapid_state_t;
  // ============================================================
  // Decoded instruction
  typedef struct packed {
    logic extest;
    logic id_sel;
    logic bsr_sel;
    logic hiz;
    logic byp_sel;
  } tapid_ctrl_t;
endpackage : tapid_pkg

// [src/tapid_fsm.sv]
module tapid_fsm import tapid_pkg::*; (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic tck_rise_in,
  input wire logic tms_in,
  output tapid_state_t state_out
);
  // ============================================================
  // Next state
  tapid_state_t next_state;
  always_comb begin
    case (state_out)
      TAPID_TLR: next_state = tms_in ? TAPID_TLR : TAPID_RTI;
      TAPID_RTI: next_state = tms_in ? TAPID_SEL_DR : TAPID_RTI;
      TAPID_SEL_DR: next_state = tms_in ? TAPID_SEL_IR : TAPID_CAP_DR;
      TAPID_CAP_DR: next_state = tms_in ? TAPID_EX1_DR : TAPID_SH_DR;
      TAPID_SH_DR: next_state = tms_in ? TAPID_EX1_DR : TAPID_SH_DR;
      TAPID_EX1_DR: next_state = tms_in ? TAPID_UPD_DR : TAPID_PA_DR;
      TAPID_PA_DR: next_state = tms_in ? TAPID_EX2_DR : TAPID_PA_DR;
      TAPID_EX2_DR: next_state = tms_in ? TAPID_UPD_DR : TAPID_SH_DR;
      TAPID_UPD_DR: next_state = tms_in ? TAPID_SEL_DR : TAPID_RTI;
      TAPID_SEL_IR: next_state = tms_in ? TAPID_TLR : TAPID_CAP_IR;
      TAPID_CAP_IR: next_state = tms_in ? TAPID_EX1_IR : TAPID_SH_IR;
      TAPID_SH_IR: next_state = tms_in ? TAPID_EX1_IR : TAPID_SH_IR;
      TAPID_EX1_IR: next_state = tms_in ? TAPID_UPD_IR : TAPID_PA_IR;
      TAPID_PA_IR: next_state = tms_in ? TAPID_EX2_IR : TAPID_PA_IR;
      TAPID_EX2_IR: next_state = tms_in ? TAPID_UPD_IR : TAPID_SH_IR;
      TAPID_UPD_IR: next_state = tms_in ? TAPID_SEL_DR : TAPID_RTI;
      default: next_state = TAPID_TLR;
    endcase
  end

  // Power-up lands in Test-Logic-Reset; five TMS highs return there
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_out <= TAPID_TLR;
    end else if (tck_rise_in) begin
      state_out <= next_state;
    end
  end
endmodule : tapid_fsm

// [src/tapid_top.sv]
`include "tapid_params.svh"
// How it works
// - Bypass code shifts through bypass register
// - Sample/preload captures pin buffers in Capture-DR
// - Non-pin cells capture fixed defaults
// - Sample/preload shifts boundary register in Shift-DR
// - All-zero code runs external test
// - External test never blocks memory inputs
// - External test drives outputs at Update-IR fall
// - External test captures pins and defaults
// - Identification captures ROM, then shifts it
// - Identification active at reset and Test-Logic-Reset
// - High-Z sample floats outputs, shifts boundary
// - Echo clock outputs keep driving
// - Codes read MSB left, LSB right
// - Three-bit instruction shifted in Shift-IR
// - Capture-IR loads 01 into low bits
// - New instruction acts only from Update-IR
// - Bypass is one flip-flop, one TCK delay
module tapid_top import tapid_pkg::*; #(
  // Arbitrary identification value, bit 0 set as the standard asks
  parameter logic [`TAPID_ID_W-1:0] ID_CODE = 32'h0A5A_5001
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  input wire logic [`TAPID_BSR_LEN-1:0] pins_in,
  output logic tdo_out,
  output logic tdo_oe_n_out,
  output logic ext_drive_out,
  output logic [`TAPID_BSR_LEN-1:0] ext_data_out,
  output logic mem_out_hiz_out,
  output logic echo_clock_output_hiz_out
);
  // ============================================================
  // Pin synchronisers
  logic [`TAPID_SYNC_W-1:0] raw;
  logic [`TAPID_SYNC_W-1:0] sync1;
  logic [`TAPID_SYNC_W-1:0] sync2;
  logic [`TAPID_SYNC_W-1:0] sync3;
  logic [`TAPID_SYNC_W-1:0] filt;
  assign raw = {pins_in, tdi_in, tms_in, tck_in};

  genvar g;
  generate
    for (g = 0; g < `TAPID_SYNC_W; g = g + 1) begin : g_sync
      always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          sync1[g] <= 1'h1;
          sync2[g] <= 1'h1;
          sync3[g] <= 1'h1;
          filt[g] <= 1'h1;
        end else begin
          sync1[g] <= raw[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          // Only an agreed level counts, so a glitch is ignored
          if (sync2[g] == sync3[g]) begin
            filt[g] <= sync3[g];
          end
        end
      end
    end
  endgenerate

  wire tck_rise = sync2[`TAPID_PIN_TCK] & sync3[`TAPID_PIN_TCK] & ~filt[`TAPID_PIN_TCK];
  wire tck_fall = ~sync2[`TAPID_PIN_TCK] & ~sync3[`TAPID_PIN_TCK] & filt[`TAPID_PIN_TCK];
  wire tms = filt[`TAPID_PIN_TMS];
  wire tdi = filt[`TAPID_PIN_TDI];
  wire [`TAPID_BSR_LEN-1:0] pins_f = filt[`TAPID_PIN_MEM +: `TAPID_BSR_LEN];

  // ============================================================
  // Controller
  tapid_state_t state;
  tapid_fsm u_fsm (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .tck_rise_in(tck_rise),
    .tms_in(tms),
    .state_out(state)
  );

  // ============================================================
  // Instruction decode
  logic [`TAPID_IR_W-1:0] ir_shift;
  logic [`TAPID_IR_W-1:0] ir;
  tapid_ctrl_t ctrl;
  wire is_extest = (ir == `TAPID_IR_EXTEST);
  wire is_id = (ir == `TAPID_IR_IDCODE);
  wire is_hiz = (ir == `TAPID_IR_SAMPLEZ);
  wire is_pre = (ir == `TAPID_IR_PRELOAD);
  wire is_bsr = is_extest | is_hiz | is_pre;
  // Bypass code and every private code select the bypass flop
  assign ctrl = '{extest: is_extest, id_sel: is_id, bsr_sel: is_bsr, hiz: is_hiz,
                  byp_sel: ~is_bsr & ~is_id};

  wire cap_dr = tck_rise & (state == TAPID_CAP_DR);
  wire sh_dr = tck_rise & (state == TAPID_SH_DR);
  wire upd_ir = tck_fall & (state == TAPID_UPD_IR);
  wire upd_dr = tck_fall & (state == TAPID_UPD_DR);

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ir_shift <= `TAPID_IR_IDCODE;
    end else if (tck_rise && state == TAPID_CAP_IR) begin
      ir_shift <= {`TAPID_IR_CAP_MSB, `TAPID_IR_CAPTURE};
    end else if (tck_rise && state == TAPID_SH_IR) begin
      ir_shift <= {tdi, ir_shift[`TAPID_IR_W-1:1]};
    end
  end

  // Held instruction only moves at Update-IR, or back to identify
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ir <= `TAPID_IR_IDCODE;
    end else if (state == TAPID_TLR) begin
      ir <= `TAPID_IR_IDCODE;
    end else if (upd_ir) begin
      ir <= ir_shift;
    end
  end

  // ============================================================
  // Data registers
  logic [`TAPID_BSR_LEN-1:0] bsr;
  logic [`TAPID_ID_W-1:0] id_reg;
  logic byp;
  // Pins filtered too; a pin still moving at capture gives no repeatable value
  wire [`TAPID_BSR_LEN-1:0] bsr_capture = (pins_f & `TAPID_BSR_PIN_MASK) |
                                           (`TAPID_BSR_DEFAULT & ~`TAPID_BSR_PIN_MASK);

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bsr <= `TAPID_BSR_DEFAULT;
    end else if (cap_dr && ctrl.bsr_sel) begin
      bsr <= bsr_capture;
    end else if (sh_dr && ctrl.bsr_sel) begin
      bsr <= {tdi, bsr[`TAPID_BSR_LEN-1:1]};
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      id_reg <= ID_CODE;
    end else if (cap_dr && ctrl.id_sel) begin
      id_reg <= ID_CODE;
    end else if (sh_dr && ctrl.id_sel) begin
      id_reg <= {tdi, id_reg[`TAPID_ID_W-1:1]};
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      byp <= `TAPID_BYP_CAPTURE;
    end else if (cap_dr && ctrl.byp_sel) begin
      byp <= `TAPID_BYP_CAPTURE;
    end else if (sh_dr && ctrl.byp_sel) begin
      byp <= tdi;
    end
  end

  // ============================================================
  // Output drive
  // Loading on Update-IR lets a fresh external test drive at once
  wire hold_load = (upd_ir && ir_shift == `TAPID_IR_EXTEST) || (upd_dr && ctrl.bsr_sel);
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ext_data_out <= `TAPID_BSR_DEFAULT;
    end else if (hold_load) begin
      ext_data_out <= bsr;
    end
  end
  // Only outputs are steered; memory inputs pass untouched
  assign ext_drive_out = ctrl.extest;
  assign mem_out_hiz_out = ctrl.hiz;
  assign echo_clock_output_hiz_out = 1'h0;

  // ============================================================
  // Test data out, launched on the falling edge
  wire dr_bit = ctrl.bsr_sel ? bsr[0] : (ctrl.id_sel ? id_reg[0] : byp);
  wire in_sh_dr = (state == TAPID_SH_DR);
  wire in_sh_ir = (state == TAPID_SH_IR);
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tdo_out <= 1'h0;
      tdo_oe_n_out <= 1'h1;
    end else if (tck_fall) begin
      tdo_out <= in_sh_ir ? ir_shift[0] : dr_bit;
      tdo_oe_n_out <= ~(in_sh_dr | in_sh_ir);
    end
  end

  // ============================================================
  // Checks
  sequence s_bsr_shift_fall;
    tck_fall && in_sh_dr && ctrl.bsr_sel;
  endsequence
  sequence s_id_capture;
    cap_dr && ctrl.id_sel;
  endsequence

  a_tlr_sets_id: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state == TAPID_TLR |=> ir == `TAPID_IR_IDCODE) else $error("instruction not identify after reset state");
  a_ir_holds_value: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !upd_ir && state != TAPID_TLR |=> $stable(ir)) else $error("instruction changed outside update");
  a_capir_pattern: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    tck_rise && state == TAPID_CAP_IR |=> ir_shift[1:0] == `TAPID_IR_CAPTURE) else $error("capture-ir pattern wrong");
  a_bypass_one_flop: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    sh_dr && ctrl.byp_sel |=> byp == $past(tdi)) else $error("bypass flop did not take tdi");
  a_id_capture_rom: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_id_capture |=> id_reg == ID_CODE) else $error("id register not loaded");
  a_bsr_capture_pins: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    cap_dr && ctrl.bsr_sel |=> bsr == (($past(pins_f) & `TAPID_BSR_PIN_MASK) |
      (`TAPID_BSR_DEFAULT & ~`TAPID_BSR_PIN_MASK))) else $error("boundary capture wrong");
  a_hiz_keeps_echo: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ir == `TAPID_IR_SAMPLEZ |-> mem_out_hiz_out && !echo_clock_output_hiz_out && ctrl.bsr_sel)
    else $error("high-z sample output state wrong");
  a_extest_update_drive: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    upd_ir && ir_shift == `TAPID_IR_EXTEST |=> ext_drive_out && ext_data_out == $past(bsr))
    else $error("external test did not drive boundary data");
  a_private_bypass: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ir == `TAPID_IR_PRIV_A || ir == `TAPID_IR_PRIV_B || ir == `TAPID_IR_PRIV_C ||
    ir == `TAPID_IR_BYPASS |-> ctrl.byp_sel && !mem_out_hiz_out)
    else $error("private code not bypass");
  a_bsr_tdo_lsb: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_bsr_shift_fall |=> tdo_out == $past(bsr[0]) && !tdo_oe_n_out) else $error("tdo not boundary lsb");
endmodule : tapid_top

// [verif/tapid_ctl_model.sv]
// ============================================================
// Test controller on the far side of the TAP pins
module tapid_ctl_model (
  input wire logic clk_in,
  input wire logic tdo_in,
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  output logic done_out,
  output logic [31:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // TCK parks high between frames, as the pull-up would leave it
  initial begin
    tck_out = 1'b1;
    tms_out = 1'b1;
    tdi_out = 1'b1;
    done_out = 1'b0;
    data_out = 32'h0;
  end
  // One TCK period of 32 ns; TDO read just before the next fall
  task automatic tck_bit(input logic tms, input logic tdi, output logic tdo);
    @(negedge clk_in);
    tck_out = 1'b0;
    tms_out = tms;
    tdi_out = tdi;
    repeat (4) @(negedge clk_in);
    tck_out = 1'b1;
    repeat (3) @(negedge clk_in);
    tdo = tdo_in;
  endtask : tck_bit
  // Five ones reach Test-Logic-Reset from anywhere, then idle
  task automatic reset_tap;
    logic b;
    repeat (5) tck_bit(1'b1, 1'b1, b);
    tck_bit(1'b0, 1'b1, b);
  endtask : reset_tap
  // ============================================================
  // Full scan from and back to Run-Test/Idle
  task automatic scan(input logic is_ir, input int n, input logic [31:0] din);
    logic [31:0] dout;
    logic b;
    int i;
    dout = 32'h0;
    tck_bit(1'b1, 1'b1, b);
    if (is_ir) tck_bit(1'b1, 1'b1, b);
    tck_bit(1'b0, 1'b1, b);
    tck_bit(1'b0, 1'b1, b);
    for (i = 0; i < n; i++) begin
      tck_bit(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tck_bit(1'b1, 1'b1, b);
    tck_bit(1'b0, 1'b1, b);
    tdi_out = 1'b1;
    data_out = dout;
    done_out = 1'b1;
    @(negedge clk_in);
    done_out = 1'b0;
  endtask : scan
endmodule : tapid_ctl_model

// [verif/tb.sv]
`include "tapid_params.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary identification value, bit 0 set
  localparam logic [31:0] ID = 32'h1234_5679;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] pins_in = 8'h00;
  logic tck, tms, tdi, tdo, oe_n, drv, hiz, echo_hiz, done;
  logic [7:0] ext_data;
  logic [31:0] data;
  logic [31:0] exp_q[$];
  logic [31:0] exp_word;
  logic [7:0] last_din;
  integer seed = 49;
  int num_errors = 0;
  int n_checks = 0;
  always #2 clk_in = ~clk_in;
  tapid_top #(.ID_CODE(ID)) dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .tck_in(tck), .tms_in(tms),
    .tdi_in(tdi), .pins_in(pins_in), .tdo_out(tdo), .tdo_oe_n_out(oe_n), .ext_drive_out(drv),
    .ext_data_out(ext_data), .mem_out_hiz_out(hiz), .echo_clock_output_hiz_out(echo_hiz));
  tapid_ctl_model ctl_u (.clk_in(clk_in), .tdo_in(tdo), .tck_out(tck), .tms_out(tms), .tdi_out(tdi),
    .done_out(done), .data_out(data));
  // ============================================================
  // Scoreboard: oldest note against each finished scan
  always @(posedge clk_in) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) `CHK(exp_q.size(), 1)
      else begin
        exp_word = exp_q.pop_front();
        `CHK(data, exp_word)
      end
    end
  end
  task automatic close_out;
    `CHK(exp_q.size(), 0)
    $display("Checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  // ============================================================
  // Instruction load and decode check
  task automatic load_ir(input logic [2:0] code);
    exp_q.push_back(32'h1);
    ctl_u.scan(1'b1, 3, {29'h0, code});
    repeat (2) @(negedge clk_in);
    `CHK(drv, code == 3'h0)
    `CHK(hiz, code == 3'h2)
    `CHK(echo_hiz, 1'b0)
    `CHK(oe_n, 1'b1)
  endtask : load_ir
  // Data scan; pins held steady for the whole scan
  task automatic dr(input logic [2:0] code);
    logic [31:0] din;
    logic [31:0] e;
    logic bnd;
    int n;
    @(negedge clk_in);
    din = 32'($random(seed));
    last_din = din[7:0];
    pins_in = 8'($random(seed));
    bnd = code == 3'h0 || code == 3'h2 || code == 3'h4;
    n = 9;
    e = {23'h0, din[7:0], 1'b0};
    if (code == 3'h1) begin
      n = 32;
      e = ID;
    end
    if (bnd) begin
      n = 8;
      e = {24'h0, (pins_in & `TAPID_BSR_PIN_MASK) | `TAPID_BSR_DEFAULT};
    end
    exp_q.push_back(e);
    ctl_u.scan(1'b0, n, din);
    repeat (2) @(negedge clk_in);
    if (bnd) `CHK(ext_data, din[7:0])
  endtask : dr
  // ============================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    sys_rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    `CHK(ext_data, `TAPID_BSR_DEFAULT)
    `CHK(drv, 1'b0)
    ctl_u.reset_tap();
    dr(3'h1);
    for (int c = 0; c < 8; c++) begin
      load_ir(3'(c));
      dr(3'(c));
    end
    load_ir(3'h4);
    dr(3'h4);
    load_ir(3'h0);
    `CHK(ext_data, last_din)
    ctl_u.reset_tap();
    repeat (2) @(negedge clk_in);
    `CHK(drv, 1'b0)
    dr(3'h1);
    close_out();
  end
endmodule : tb
